// [src/dpio_consts.svh]
// Offsets, reset values and field positions of the dual parallel I/O port block
`ifndef DPIO_CONSTS_SVH
`define DPIO_CONSTS_SVH

// ==========================================
// Address map
`define DPIO_SFR_LAST       16'h003F
`define DPIO_OFS_P0_LATCH   16'h0000
`define DPIO_OFS_P1_LATCH   16'h0001
`define DPIO_OFS_P0_PINS    16'h0008
`define DPIO_OFS_P1_DIR     16'h000D
`define DPIO_OFS_IRQ_CTRL   16'h0037

// ==========================================
// Field positions
`define DPIO_IRQ0_SEL_POS   6

// ==========================================
// Reset and idle values
`define DPIO_RST_P0_LATCH   8'hFF
`define DPIO_RST_P1_LATCH   8'h00
`define DPIO_RST_P1_DIR     8'h00
`define DPIO_RST_IRQ0_SEL   1'h0
`define DPIO_RD_UNMAPPED    8'h00
`define DPIO_PADS_RELEASED  8'hFF
`define DPIO_PADS_LOW       8'h00

`endif

// [src/dpio_pkg.sv]
// Types shared by the dual parallel I/O port block
package dpio_pkg;

    // ==========================================
    // CPU access kinds
    typedef enum logic [1:0] {
        DPIO_OP_READ,
        DPIO_OP_WRITE,
        DPIO_OP_BSET,
        DPIO_OP_BCLR
    } dpio_op_t;

    // Access phases of one instruction cycle
    typedef enum logic [1:0] {
        DPIO_PH_IDLE,
        DPIO_PH_READ_SAMPLE,
        DPIO_PH_WRITE_UPDATE
    } dpio_phase_t;

    // Decoded register targets
    typedef enum logic [2:0] {
        DPIO_REG_NONE,
        DPIO_REG_P0_LATCH,
        DPIO_REG_P1_LATCH,
        DPIO_REG_P0_PINS,
        DPIO_REG_P1_DIR,
        DPIO_REG_IRQ_CTRL
    } dpio_reg_t;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic        valid;
        dpio_op_t    op;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [2:0]  bitsel;
    } dpio_req_t;

    typedef struct packed {
        logic       ack;
        logic       err;
        logic       busy;
        logic [7:0] rdata;
    } dpio_rsp_t;

    typedef struct packed {
        logic [7:0] en;
        logic [7:0] out;
    } dpio_sec_t;

    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] oe_n;
    } dpio_pad_t;

    // ==========================================
    // Module states
    typedef struct packed {
        logic [7:0] latch;
        dpio_pad_t  pad;
    } dpio_p0_st_t;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        dpio_pad_t  pad;
    } dpio_p1_st_t;

    typedef struct packed {
        dpio_phase_t phase;
        dpio_req_t   req;
        logic [7:0]  rdata_work;
        dpio_rsp_t   rsp;
        logic        irq0_sel;
        logic        ext_irq0;
    } dpio_top_st_t;

endpackage : dpio_pkg

// [src/dpio_port0.sv]
// Port 0: reset-to-one output latch and open-drain style pad drive
`include "dpio_consts.svh"

module dpio_port0 (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // Latch write from the access sequencer
    input  wire logic              wr_en,
    input  wire logic [7:0]        wdata,
    // Pin function select and secondary functions
    input  wire logic              irq0_sel,
    input  wire dpio_pkg::dpio_sec_t sec,
    // Latch contents and pads
    output logic [7:0]             latch,
    output dpio_pkg::dpio_pad_t    pad
);

    dpio_pkg::dpio_p0_st_t st_ff;   // Whole state
    dpio_pkg::dpio_p0_st_t nxt_st;  // Next state

    // ==========================================
    // Next latch and pad levels
    always_comb begin
        nxt_st = st_ff;
        if (wr_en) begin
            nxt_st.latch = wdata;
        end
        // Pad level computed from the next latch so pins move with the write
        nxt_st.pad.drive = `DPIO_PADS_LOW;
        nxt_st.pad.oe_n  = nxt_st.latch & (~sec.en | sec.out);
        if (irq0_sel) begin
            nxt_st.pad.oe_n[0] = 1'b1;
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_ff.latch     <= `DPIO_RST_P0_LATCH;
            st_ff.pad.drive <= `DPIO_PADS_LOW;
            st_ff.pad.oe_n  <= `DPIO_PADS_RELEASED;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign latch = st_ff.latch;
    assign pad   = st_ff.pad;

endmodule // dpio_port0

// [src/dpio_port1.sv]
// Port 1: per-bit direction register and output latch
`include "dpio_consts.svh"

module dpio_port1 (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // Writes from the access sequencer
    input  wire logic              latch_wr,
    input  wire logic              dir_wr,
    input  wire logic [7:0]        wdata,
    // Secondary functions
    input  wire dpio_pkg::dpio_sec_t sec,
    // Register contents and pads
    output logic [7:0]             latch,
    output logic [7:0]             dir,
    output dpio_pkg::dpio_pad_t    pad
);

    dpio_pkg::dpio_p1_st_t st_ff;   // Whole state
    dpio_pkg::dpio_p1_st_t nxt_st;  // Next state

    // ==========================================
    // Next latch, direction and pads
    always_comb begin
        nxt_st = st_ff;
        // Latch takes data in any direction so outputs can be preloaded
        if (latch_wr) begin
            nxt_st.latch = wdata;
        end
        if (dir_wr) begin
            nxt_st.dir = wdata;
        end
        nxt_st.pad.drive = nxt_st.latch & (~sec.en | sec.out);
        nxt_st.pad.oe_n  = ~nxt_st.dir;
    end

    // ==========================================
    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_ff.latch     <= `DPIO_RST_P1_LATCH;
            st_ff.dir       <= `DPIO_RST_P1_DIR;
            st_ff.pad.drive <= `DPIO_PADS_LOW;
            st_ff.pad.oe_n  <= `DPIO_PADS_RELEASED;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign latch = st_ff.latch;
    assign dir   = st_ff.dir;
    assign pad   = st_ff.pad;

endmodule // dpio_port1

// [src/dpio_top.sv]
// Dual parallel I/O port: CPU access sequencer, register decode and both ports
`include "dpio_consts.svh"

module dpio_top (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    // CPU byte access
    input  wire dpio_pkg::dpio_req_t cpu_req,
    output dpio_pkg::dpio_rsp_t      cpu_rsp,
    // Port 0 pads
    input  wire logic [7:0]          p0_pad_level,
    output dpio_pkg::dpio_pad_t      p0_pad,
    // Port 0 secondary functions
    input  wire dpio_pkg::dpio_sec_t p0_sec,
    output logic                     ext_irq0_input,
    // Port 1 pads
    input  wire logic [7:0]          p1_pad_level,
    output dpio_pkg::dpio_pad_t      p1_pad,
    // Port 1 secondary functions
    input  wire dpio_pkg::dpio_sec_t p1_sec
);

    // ==========================================
    // Helpers

    // Map a byte address onto a register of this block
    function automatic dpio_pkg::dpio_reg_t decode_addr(input logic [15:0] addr);
        dpio_pkg::dpio_reg_t r;
        r = dpio_pkg::DPIO_REG_NONE;
        // Nothing above the special function area belongs here
        if (addr <= `DPIO_SFR_LAST) begin
            case (addr)
                `DPIO_OFS_P0_LATCH: r = dpio_pkg::DPIO_REG_P0_LATCH;
                `DPIO_OFS_P1_LATCH: r = dpio_pkg::DPIO_REG_P1_LATCH;
                `DPIO_OFS_P0_PINS:  r = dpio_pkg::DPIO_REG_P0_PINS;
                `DPIO_OFS_P1_DIR:   r = dpio_pkg::DPIO_REG_P1_DIR;
                `DPIO_OFS_IRQ_CTRL: r = dpio_pkg::DPIO_REG_IRQ_CTRL;
                default:            r = dpio_pkg::DPIO_REG_NONE;
            endcase
        end
        return r;
    endfunction

    // True for accesses that write something back
    function automatic logic is_write_op(input dpio_pkg::dpio_op_t op);
        return (op != dpio_pkg::DPIO_OP_READ);
    endfunction

    // Set or clear one bit of a byte
    function automatic logic [7:0] modify_bit(
        input logic [7:0] value,
        input logic [2:0] pos,
        input logic       set
    );
        logic [7:0] v;
        v      = value;
        v[pos] = set;
        return v;
    endfunction

    // ==========================================
    // Declarations
    dpio_pkg::dpio_top_st_t st_ff;      // Whole sequencer state
    dpio_pkg::dpio_top_st_t nxt_st;     // Next sequencer state
    dpio_pkg::dpio_reg_t    cur_reg;    // Register hit by the held request
    logic [7:0]             p0_latch;   // Port 0 output latch
    logic [7:0]             p1_latch;   // Port 1 output latch
    logic [7:0]             p1_dir;     // Port 1 direction
    logic [7:0]             p1_view;    // Port 1 read view
    logic [7:0]             rd_value;   // Value seen in the sample state
    logic [7:0]             wr_value;   // Value written in the update state
    logic                   p0_wr;      // Port 0 latch write strobe
    logic                   p1_lat_wr;  // Port 1 latch write strobe
    logic                   p1_dir_wr;  // Port 1 direction write strobe
    logic                   bad_acc;    // Access that this block refuses

    // ==========================================
    // Port blocks
    dpio_port0 u_port0 (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .wr_en    (p0_wr),
        .wdata    (wr_value),
        .irq0_sel (nxt_st.irq0_sel),    // Next select, so pin 0 turns on the ack edge
        .sec      (p0_sec),
        .latch    (p0_latch),
        .pad      (p0_pad)
    );

    dpio_port1 u_port1 (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .latch_wr (p1_lat_wr),
        .dir_wr   (p1_dir_wr),
        .wdata    (wr_value),
        .sec      (p1_sec),
        .latch    (p1_latch),
        .dir      (p1_dir),
        .pad      (p1_pad)
    );

    // ==========================================
    // Read path

    // Outputs show the latch, inputs show the live pin, no input latch
    always_comb begin
        p1_view = (p1_dir & p1_latch) | (~p1_dir & p1_pad_level);
    end

    // Decode of the request held for the current access
    always_comb begin
        cur_reg = decode_addr(st_ff.req.addr);
    end

    // Byte returned for the held request, evaluated in the sample state
    always_comb begin
        rd_value = `DPIO_RD_UNMAPPED;
        case (cur_reg)
            dpio_pkg::DPIO_REG_P0_LATCH: begin
                rd_value = p0_latch;
            end
            dpio_pkg::DPIO_REG_P0_PINS: begin
                rd_value = p0_pad_level;
            end
            dpio_pkg::DPIO_REG_P1_LATCH: begin
                rd_value = p1_view;
            end
            dpio_pkg::DPIO_REG_P1_DIR: begin
                rd_value = p1_dir;
            end
            dpio_pkg::DPIO_REG_IRQ_CTRL: begin
                // Only the pin select bit lives here, the rest reads zero
                rd_value = `DPIO_RD_UNMAPPED;
                rd_value[`DPIO_IRQ0_SEL_POS] = st_ff.irq0_sel;
            end
            default: begin
                rd_value = `DPIO_RD_UNMAPPED;
            end
        endcase
    end

    // ==========================================
    // Write path

    // Plain writes use the CPU byte; bit operations reuse the sampled
    // byte, so input bits of port 1 carry their pin level back into
    // the latch. That is the documented side effect, not a bug.
    always_comb begin
        case (st_ff.req.op)
            dpio_pkg::DPIO_OP_BSET: begin
                wr_value = modify_bit(st_ff.rdata_work, st_ff.req.bitsel, 1'b1);
            end
            dpio_pkg::DPIO_OP_BCLR: begin
                wr_value = modify_bit(st_ff.rdata_work, st_ff.req.bitsel, 1'b0);
            end
            default: begin
                wr_value = st_ff.req.wdata;
            end
        endcase
    end

    // Refused: unmapped or reserved address, or a write to the pin view
    always_comb begin
        bad_acc = (cur_reg == dpio_pkg::DPIO_REG_NONE) ||
                  ((cur_reg == dpio_pkg::DPIO_REG_P0_PINS) &&
                   is_write_op(st_ff.req.op));
    end

    // Write strobes fire only in the update state
    always_comb begin
        p0_wr     = 1'b0;
        p1_lat_wr = 1'b0;
        p1_dir_wr = 1'b0;
        if ((st_ff.phase == dpio_pkg::DPIO_PH_WRITE_UPDATE) &&
            is_write_op(st_ff.req.op)) begin
            p0_wr     = (cur_reg == dpio_pkg::DPIO_REG_P0_LATCH);
            p1_lat_wr = (cur_reg == dpio_pkg::DPIO_REG_P1_LATCH);
            p1_dir_wr = (cur_reg == dpio_pkg::DPIO_REG_P1_DIR);
        end
    end

    // ==========================================
    // Access sequencer: idle, sample, update
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.rsp.ack = 1'b0;
        nxt_st.rsp.err = 1'b0;
        case (st_ff.phase)
            dpio_pkg::DPIO_PH_IDLE: begin
                // A new access is only taken while idle
                if (cpu_req.valid) begin
                    nxt_st.req      = cpu_req;
                    nxt_st.phase    = dpio_pkg::DPIO_PH_READ_SAMPLE;
                    nxt_st.rsp.busy = 1'b1;
                end
            end
            dpio_pkg::DPIO_PH_READ_SAMPLE: begin
                // Pins are caught here; later bounce is not seen
                nxt_st.rdata_work = rd_value;
                nxt_st.phase      = dpio_pkg::DPIO_PH_WRITE_UPDATE;
            end
            dpio_pkg::DPIO_PH_WRITE_UPDATE: begin
                // Latches and pads change on this edge, with the answer
                if (is_write_op(st_ff.req.op) &&
                    (cur_reg == dpio_pkg::DPIO_REG_IRQ_CTRL)) begin
                    nxt_st.irq0_sel = wr_value[`DPIO_IRQ0_SEL_POS];
                end
                nxt_st.rsp.ack   = 1'b1;
                nxt_st.rsp.err   = bad_acc;
                nxt_st.rsp.rdata = st_ff.rdata_work;
                nxt_st.rsp.busy  = 1'b0;
                nxt_st.phase     = dpio_pkg::DPIO_PH_IDLE;
            end
            default: begin
                nxt_st.phase    = dpio_pkg::DPIO_PH_IDLE;
                nxt_st.rsp.busy = 1'b0;
            end
        endcase
        // Interrupt pin follows the pad only when selected, else idles high
        nxt_st.ext_irq0 = st_ff.irq0_sel ? p0_pad_level[0] : 1'b1;
    end

    // ==========================================
    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_ff.phase      <= dpio_pkg::DPIO_PH_IDLE;
            st_ff.req        <= '0;
            st_ff.rdata_work <= `DPIO_RD_UNMAPPED;
            st_ff.rsp        <= '0;
            st_ff.irq0_sel   <= `DPIO_RST_IRQ0_SEL;
            st_ff.ext_irq0   <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================
    // Outputs straight from the state register
    assign cpu_rsp        = st_ff.rsp;
    assign ext_irq0_input = st_ff.ext_irq0;

endmodule // dpio_top

// [testbench/dpio_checker.sv]
// Concurrent checks on the ports of the dual parallel I/O port top
module dpio_checker (
    // Clock and reset
    input wire logic                clk_sys,
    input wire logic                reset_n,
    // CPU byte access
    input wire dpio_pkg::dpio_req_t cpu_req,
    input wire dpio_pkg::dpio_rsp_t cpu_rsp,
    // Port 0 side
    input wire logic [7:0]          p0_pad_level,
    input wire dpio_pkg::dpio_pad_t p0_pad,
    input wire dpio_pkg::dpio_sec_t p0_sec,
    input wire logic                ext_irq0_input,
    // Port 1 side
    input wire logic [7:0]          p1_pad_level,
    input wire dpio_pkg::dpio_pad_t p1_pad,
    input wire dpio_pkg::dpio_sec_t p1_sec
);
    // ==========================================
    // One clock domain, reset masks everything
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Request accepted by an idle sequencer
    sequence s_take;
        cpu_req.valid && !cpu_rsp.busy;
    endsequence
    // Two busy cycles, then the answer
    sequence s_answer;
        cpu_rsp.busy [*2] ##1 (cpu_rsp.ack && !cpu_rsp.busy);
    endsequence

    property p_answer;
        s_take |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("answer timing off");
    property p_ack_pulse;
        cpu_rsp.ack |=> !cpu_rsp.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_err_ack;
        cpu_rsp.err |-> cpu_rsp.ack;
    endproperty
    a_err_ack: assert property (p_err_ack) else $error("err without ack");
    // Sync reset: values seen at first edge after release
    property p_reset_vals;
        $rose(reset_n) |-> p0_pad.oe_n == 8'hFF && p1_pad.oe_n == 8'hFF
            && p1_pad.drive == 8'h00 && ext_irq0_input;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values");
    // Live pin level of the sample cycle, no input latch
    property p_pin_read;
        (s_take ##0 (cpu_req.op == dpio_pkg::DPIO_OP_READ && cpu_req.addr == 16'h0008))
            |-> ##3 (cpu_rsp.ack && cpu_rsp.rdata == $past(p0_pad_level, 2));
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read value");
    property p_pin_ro;
        (s_take ##0 (cpu_req.op == dpio_pkg::DPIO_OP_WRITE && cpu_req.addr == 16'h0008))
            |-> ##3 (cpu_rsp.ack && cpu_rsp.err);
    endproperty
    a_pin_ro: assert property (p_pin_ro) else $error("pin address written");
    property p_out_range;
        (s_take ##0 (cpu_req.addr > 16'h003F)) |-> ##3 cpu_rsp.err;
    endproperty
    a_out_range: assert property (p_out_range) else $error("outside area accepted");
    property p_p0_drive;
        p0_pad.drive == 8'h00;
    endproperty
    a_p0_drive: assert property (p_p0_drive) else $error("port0 drives high");
    // Pads move only on an answer or a secondary input change
    property p_p1_cause;
        !$stable(p1_pad) |-> cpu_rsp.ack || $past(p1_sec) != $past(p1_sec, 2);
    endproperty
    a_p1_cause: assert property (p_p1_cause) else $error("port1 pad moved");
    property p_p0_cause;
        // Latch of ones meets the secondary gating one edge after reset lets go
        !$stable(p0_pad.oe_n) |-> cpu_rsp.ack || $past(p0_sec) != $past(p0_sec, 2)
            || !$past(reset_n, 2);
    endproperty
    a_p0_cause: assert property (p_p0_cause) else $error("port0 pad moved");
    property p_irq_in;
        !ext_irq0_input |-> !$past(p0_pad_level[0]);
    endproperty
    a_irq_in: assert property (p_irq_in) else $error("irq0 low without pin");
endmodule // dpio_checker

bind dpio_top dpio_checker i_dpio_checker (
    .clk_sys(clk_sys), .reset_n(reset_n), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
    .p0_pad_level(p0_pad_level), .p0_pad(p0_pad), .p0_sec(p0_sec),
    .ext_irq0_input(ext_irq0_input), .p1_pad_level(p1_pad_level), .p1_pad(p1_pad),
    .p1_sec(p1_sec)
);

// [testbench/dpio_pins_model.sv]
// Outside world at the pins: resolves pad drive against external levels
module dpio_pins_model (
    // Pads from the block
    input wire dpio_pkg::dpio_pad_t p0_pad,
    input wire dpio_pkg::dpio_pad_t p1_pad,
    // Levels of outside drivers or pull-ups on released pins
    input wire logic [7:0]          ext_p0,
    input wire logic [7:0]          ext_p1,
    // Resolved pin levels
    output logic [7:0]              p0_level,
    output logic [7:0]              p1_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Released bit shows the outside level, driven bit the pad
    always_comb begin
        p0_level = (p0_pad.oe_n & ext_p0) | (~p0_pad.oe_n & p0_pad.drive);
        p1_level = (p1_pad.oe_n & ext_p1) | (~p1_pad.oe_n & p1_pad.drive);
    end
endmodule // dpio_pins_model

// [testbench/tb_dual_parallel_io_port.sv]
// Self-checking bench for the dual parallel I/O port
module tb_dual_parallel_io_port;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Signals
    logic                clk_sys = 1'b0;
    logic                reset_n = 1'b0;
    dpio_pkg::dpio_req_t req     = '0;
    dpio_pkg::dpio_rsp_t rsp;
    dpio_pkg::dpio_sec_t sec0    = '0;
    dpio_pkg::dpio_sec_t sec1    = '0;
    dpio_pkg::dpio_pad_t pad0, pad1;
    dpio_pkg::dpio_op_t  op;
    logic [7:0]          lvl0, lvl1, rd, lat0, lat1, dir1, mix;
    logic [7:0]          ext0    = 8'hFF;
    logic [7:0]          ext1    = 8'h00;
    logic [2:0]          b;
    logic                irq0, er;
    logic [15:0]         bad [3] = '{16'h0005, 16'h003E, 16'h0040};
    int                  err_count = 0;
    int                  check_count = 0;
    int                  seed = 93274;

    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;

    dpio_top i_dpio_top (.clk_sys(clk_sys), .reset_n(reset_n), .cpu_req(req), .cpu_rsp(rsp),
        .p0_pad_level(lvl0), .p0_pad(pad0), .p0_sec(sec0), .ext_irq0_input(irq0),
        .p1_pad_level(lvl1), .p1_pad(pad1), .p1_sec(sec1));
    dpio_pins_model i_dpio_pins_model (.p0_pad(pad0), .p1_pad(pad1), .ext_p0(ext0),
        .ext_p1(ext1), .p0_level(lvl0), .p1_level(lvl1));

    // ==========================================
    // Helpers
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] ex);
        check_count++;
        if (got !== ex) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Pad level that a latch and secondary gating give
    function automatic logic [7:0] f_pad(input logic [7:0] l, input dpio_pkg::dpio_sec_t s,
                                         input logic sel);
        f_pad = l & (~s.en | s.out);
        if (sel) f_pad[0] = 1'b1;
    endfunction

    // One byte access; valid dropped once taken, since a held valid would repeat it
    task automatic acc(input dpio_pkg::dpio_op_t o, input logic [15:0] a, input logic [7:0] wd,
                       input logic [2:0] bs);
        int n;
        n = 0;
        req = '{1'b1, o, a, wd, bs};
        @(posedge clk_sys);
        #1 req.valid = 1'b0;
        while (rsp.ack !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            #1 n++;
        end
        rd = rsp.rdata;
        er = rsp.err;
        // Ack is launched by the second edge after the taking one
        chk("ack latency", 8'(n), 8'h02);
    endtask

    // Reset, then reset values at pads and registers
    task automatic rst(input int cyc);
        reset_n = 1'b0;
        repeat (cyc) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        lat0 = 8'hFF;
        chk("p0 oe reset", pad0.oe_n, 8'hFF);
        chk("p1 oe reset", pad1.oe_n, 8'hFF);
        chk("irq0 reset", {7'h00, irq0}, 8'h01);
        acc(dpio_pkg::DPIO_OP_READ, 16'h0000, 8'h00, 3'h0);
        chk("p0 latch reset", rd, 8'hFF);
        acc(dpio_pkg::DPIO_OP_READ, 16'h000D, 8'h00, 3'h0);
        chk("p1 dir reset", rd, 8'h00);
        acc(dpio_pkg::DPIO_OP_READ, 16'h0037, 8'h00, 3'h0);
        chk("irq sel reset", rd, 8'h00);
        chk("p1 drive reset", pad1.drive, f_pad(8'h00, sec1, 1'b0));
    endtask

    task automatic finish_test;
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================
    // Watchdog, well above the expected run length
    initial begin
        #80000;
        err_count++;
        finish_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        rst(20);
        // Port 0: latch, live pins, secondary gating, bit ops on the latch
        for (int i = 0; i < 24; i++) begin
            lat0 = (i == 0) ? 8'hFF : 8'($random(seed));
            ext0 = 8'($random(seed));
            sec0 = 16'($random(seed));
            acc(dpio_pkg::DPIO_OP_WRITE, 16'h0000, lat0, 3'h0);
            chk("p0 pad", pad0.oe_n, f_pad(lat0, sec0, 1'b0));
            acc(dpio_pkg::DPIO_OP_READ, 16'h0000, 8'h00, 3'h0);
            chk("p0 latch", rd, lat0);
            acc(dpio_pkg::DPIO_OP_READ, 16'h0008, 8'h00, 3'h0);
            chk("p0 pins", rd, f_pad(lat0, sec0, 1'b0) & ext0);
            op = i[0] ? dpio_pkg::DPIO_OP_BSET : dpio_pkg::DPIO_OP_BCLR;
            b = 3'($random(seed));
            acc(op, 16'h0000, 8'h00, b);
            chk("p0 bitop old", rd, lat0);
            lat0[b] = i[0];
            chk("p0 bitop pad", pad0.oe_n, f_pad(lat0, sec0, 1'b0));
        end
        // Port 1: preload latch, set directions, mixed reads and bit ops
        for (int i = 0; i < 24; i++) begin
            lat1 = 8'($random(seed));
            dir1 = (i == 0) ? 8'hFF : 8'($random(seed));
            ext1 = 8'($random(seed));
            sec1 = 16'($random(seed));
            acc(dpio_pkg::DPIO_OP_WRITE, 16'h0001, lat1, 3'h0);
            acc(dpio_pkg::DPIO_OP_WRITE, 16'h000D, dir1, 3'h0);
            chk("p1 oe", pad1.oe_n, ~dir1);
            chk("p1 drive", pad1.drive, f_pad(lat1, sec1, 1'b0));
            acc(dpio_pkg::DPIO_OP_READ, 16'h000D, 8'h00, 3'h0);
            chk("p1 dir", rd, dir1);
            mix = (dir1 & lat1) | (~dir1 & ext1);
            acc(dpio_pkg::DPIO_OP_READ, 16'h0001, 8'h00, 3'h0);
            chk("p1 read", rd, mix);
            op = i[0] ? dpio_pkg::DPIO_OP_BSET : dpio_pkg::DPIO_OP_BCLR;
            b = 3'($random(seed));
            acc(op, 16'h0001, 8'h00, b);
            chk("p1 bitop old", rd, mix);
            lat1 = mix;
            lat1[b] = i[0];
            chk("p1 bitop latch", pad1.drive, f_pad(lat1, sec1, 1'b0));
        end
        // Refused places: pin address written, reserved and outside area
        acc(dpio_pkg::DPIO_OP_WRITE, 16'h0008, 8'h00, 3'h0);
        chk("pin write err", {7'h00, er}, 8'h01);
        foreach (bad[k]) begin
            acc(dpio_pkg::DPIO_OP_WRITE, bad[k], 8'h00, 3'h0);
            chk("bad write err", {7'h00, er}, 8'h01);
            acc(dpio_pkg::DPIO_OP_READ, bad[k], 8'h00, 3'h0);
            chk("bad read data", rd, 8'h00);
        end
        acc(dpio_pkg::DPIO_OP_READ, 16'h0000, 8'h00, 3'h0);
        chk("p0 latch kept", rd, lat0);
        // Bit 0 of port 0 as irq input, then back to a port bit
        acc(dpio_pkg::DPIO_OP_WRITE, 16'h0000, 8'hFE, 3'h0);
        acc(dpio_pkg::DPIO_OP_WRITE, 16'h0037, 8'h40, 3'h0);
        acc(dpio_pkg::DPIO_OP_READ, 16'h0037, 8'h00, 3'h0);
        chk("irq sel", rd, 8'h40);
        chk("irq pin released", {7'h00, pad0.oe_n[0]}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            ext0 = {7'h7F, i[0]};
            repeat (3) @(posedge clk_sys);
            #1 chk("irq follows pin", {7'h00, irq0}, {7'h00, i[0]});
        end
        acc(dpio_pkg::DPIO_OP_WRITE, 16'h0037, 8'h00, 3'h0);
        repeat (2) @(posedge clk_sys);
        #1 chk("irq idle", {7'h00, irq0}, 8'h01);
        chk("p00 port again", {7'h00, pad0.oe_n[0]}, 8'h00);
        // Second reset in mid-run
        rst(3);
        finish_test();
    end
endmodule // tb_dual_parallel_io_port
